// *** design/vip_top.sv ***
// Functional notes
// - Masked sources never reach the CPU, except one masked in the cycle the core acknowledges it.
// - Break instruction raises separate vectored software interrupt.
// - Simultaneous requests served lowest priority number first.
// - Watchdog request at 75 percent, priority 0.
// - Watchdog request only when its enable set.
// - Supply monitor request only while mode bit clear.
// - Four pin edge requests, priorities 2,3,4,26.
// - Serial C transmit, receive, error at 5-7.
// - DMA channel ends at priorities 8 and 9.
// - Radio link serial done at priority 10.
// - Serial A transmit modes share priority 11.
// - Serial A receive and error at 12, 13.
// - Timer unit 0 channels at 14-17, 22-25.
// - Calendar alarm 18, calendar interval 19.
// - Serial B transmit done at priority 20.
// - Timer unit 1 channels at 21, 27-29.
// - Divider completion lowest, priority 30.
`timescale 1ns/100ps
module vip_top (
  // Clock and reset.
  input  wire  logic               sys_clk,
  input  wire  logic               reset,
  // Peripheral request pulses and masks (1 masks the source).
  input  wire  vip_pkg::vip_req_s  src_req,
  input  wire  vip_pkg::vip_src_t  src_mask,
  // Software interrupt from the core.
  input  wire  logic               break_instruction,
  // Watchdog count and its configuration.
  input  wire  vip_pkg::vip_wdt_t  watchdog_count,
  input  wire  vip_pkg::vip_wdt_t  watchdog_overflow_count,
  input  wire  logic               watchdog_interval_irq_enable,
  // Supply monitor mode (1 turns the detection into a reset, not an interrupt).
  input  wire  logic               supply_monitor_mode_bit,
  // CPU side.
  input  wire  logic               cpu_ack,
  output vip_pkg::vip_vec_t        int_vector_addr,
  output logic                     int_request,
  output logic                     int_software,
  output vip_pkg::vip_idx_t        int_source_index,
  output vip_pkg::vip_src_t        pending_flags
);
  import vip_pkg::*;

  vip_state_s st;
  vip_state_s next_st;
  vip_src_t   raw_set;
  vip_src_t   set;
  vip_src_t   clr;
  vip_src_t   cand;
  vip_pick_s  pick;
  vip_wdt_t   wdt_threshold;
  logic       wdt_hit;
  logic       wdt_pulse;
  logic       soft_clr;

  // Interval point: overflow count less a quarter, which is 75 percent of it.
  assign wdt_threshold = watchdog_overflow_count - (watchdog_overflow_count >> VIP_WDT_QUARTER_SHIFT);
  assign wdt_hit       = (watchdog_count >= wdt_threshold);

  // Only the crossing counts, so a count parked above the point raises one request.
  assign wdt_pulse = wdt_hit & ~st.wdt_above & watchdog_interval_irq_enable;

  // Gather all request lines in priority order; the three serial A modes share one slot.
  assign raw_set = {
    src_req.divider_done_request,
    src_req.timer_u1_ch2_done,
    src_req.timer_u1_ch1_done,
    src_req.timer_u1_ch0_done,
    src_req.pin_edge_request_d,
    src_req.timer_u0_ch7_done,
    src_req.timer_u0_ch6_done,
    src_req.timer_u0_ch5_done,
    src_req.timer_u0_ch4_done,
    src_req.timer_u1_ch3_done,
    src_req.serial_b_tx_done,
    src_req.calendar_interval_request,
    src_req.calendar_cycle_alarm_request,
    src_req.timer_u0_ch3_done,
    src_req.timer_u0_ch2_done,
    src_req.timer_u0_ch1_done,
    src_req.timer_u0_ch0_done,
    src_req.serial_a_rx_error,
    src_req.serial_a_rx_done,
    src_req.serial_a_tx_done | src_req.clocked_serial_a_done | src_req.two_wire_a_done,
    src_req.radio_link_serial_done,
    src_req.dma_second_done,
    src_req.dma_first_done,
    src_req.serial_c_rx_error,
    src_req.serial_c_rx_done,
    src_req.serial_c_tx_done,
    src_req.pin_edge_request_c,
    src_req.pin_edge_request_b,
    src_req.pin_edge_request_a,
    src_req.supply_monitor_request,
    wdt_pulse};

  // In reset mode the supply monitor must not also leave an interrupt flag behind.
  always_comb begin
    set                 = raw_set;
    set[VIP_IDX_SUPPLY] = raw_set[VIP_IDX_SUPPLY] & ~supply_monitor_mode_bit;
  end

  // Masked flags still latch, so unmasking later delivers the held event.
  assign cand = st.pend & ~src_mask;

  vip_prio_enc u_prio_enc (
    .cand (cand),
    .pick (pick)
  );

  // Next-state logic: offer a winner, hold it stable until the core acknowledges or the source is masked.
  always_comb begin
    next_st           = st;
    clr               = '0;
    soft_clr          = 1'b0;
    next_st.wdt_above = wdt_hit;
    case (st.fsm)
      VIP_ST_IDLE: begin
        if (st.soft_pend) begin
          // The break comes from the instruction stream, so it is taken ahead of any source.
          next_st.fsm          = VIP_ST_OFFER;
          next_st.int_request  = 1'b1;
          next_st.int_software = 1'b1;
          next_st.int_index    = '0;
          next_st.int_vector   = VIP_SOFT_VECTOR;
        end else if (pick.found) begin
          next_st.fsm          = VIP_ST_OFFER;
          next_st.int_request  = 1'b1;
          next_st.int_software = 1'b0;
          next_st.int_index    = pick.idx;
          next_st.int_vector   = pick.vec;
        end
      end
      VIP_ST_OFFER: begin
        if (cpu_ack) begin
          // One request per acknowledge; the next search starts from a fresh idle cycle.
          if (st.int_software) begin
            soft_clr = 1'b1;
          end else begin
            clr[st.int_index] = 1'b1;
          end
          next_st.fsm         = VIP_ST_IDLE;
          next_st.int_request = 1'b0;
        end else if (!st.int_software && src_mask[st.int_index]) begin
          // A source masked while on offer is withdrawn and its flag is kept.
          next_st.fsm         = VIP_ST_IDLE;
          next_st.int_request = 1'b0;
        end
      end
      default: begin
        next_st.fsm         = VIP_ST_IDLE;
        next_st.int_request = 1'b0;
      end
    endcase
    // A new event in the clearing cycle survives: set wins over clear.
    next_st.pend      = (st.pend & ~clr) | set;
    next_st.soft_pend = (st.soft_pend & ~soft_clr) | break_instruction;
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= VIP_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register.
  assign int_request      = st.int_request;
  assign int_software     = st.int_software;
  assign int_vector_addr  = st.int_vector;
  assign int_source_index = st.int_index;
  assign pending_flags    = st.pend;

  // Checks. Helper: lowest-numbered candidate isolated by two's complement.
  vip_src_t cand_lowest;
  assign cand_lowest = cand & (~cand + vip_src_t'(1));

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_mask_withdraw;
    int_request && !int_software && !cpu_ack && src_mask[int_source_index] |=> !int_request;
  endproperty
  a_mask_withdraw: assert property (p_mask_withdraw)
    else $error("Masked source kept on offer.");

  property p_soft_offer;
    (st.fsm == VIP_ST_IDLE) && st.soft_pend |=> int_request && int_software && int_vector_addr == VIP_SOFT_VECTOR;
  endproperty
  a_soft_offer: assert property (p_soft_offer)
    else $error("Break not offered with its vector.");

  property p_lowest_wins;
    (st.fsm == VIP_ST_IDLE) && !st.soft_pend && (cand != '0)
      |=> int_request && ((vip_src_t'(1) << int_source_index) == $past(cand_lowest));
  endproperty
  a_lowest_wins: assert property (p_lowest_wins)
    else $error("Winner is not the lowest pending unmasked source.");

  property p_wdt_needs_enable;
    $rose(st.pend[VIP_IDX_WDT]) |-> $past(watchdog_interval_irq_enable) && $past(wdt_hit);
  endproperty
  a_wdt_needs_enable: assert property (p_wdt_needs_enable)
    else $error("Watchdog flag set without enable or crossing.");

  property p_wdt_vector;
    int_request && !int_software && int_source_index == VIP_IDX_WDT |-> int_vector_addr == VIP_VECTOR_TABLE[0];
  endproperty
  a_wdt_vector: assert property (p_wdt_vector)
    else $error("Watchdog offered with wrong vector.");

  property p_supply_gate;
    $rose(st.pend[VIP_IDX_SUPPLY]) |-> !$past(supply_monitor_mode_bit);
  endproperty
  a_supply_gate: assert property (p_supply_gate)
    else $error("Supply monitor flag set in reset mode.");

  property p_vector_table;
    int_request && !int_software |-> int_vector_addr == VIP_VECTOR_TABLE[int_source_index];
  endproperty
  a_vector_table: assert property (p_vector_table)
    else $error("Offered vector does not match source.");

  property p_ack_clears;
    int_request && !int_software && cpu_ack && !set[int_source_index]
      |=> !st.pend[$past(int_source_index)] && !int_request;
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("Acknowledge did not clear the winning flag.");

  property p_set_wins;
    int_request && !int_software && cpu_ack && set[int_source_index] |=> st.pend[$past(int_source_index)];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Event lost in its clearing cycle.");

  property p_offer_stable;
    int_request && !cpu_ack && (int_software || !src_mask[int_source_index])
      |=> int_request && $stable(int_vector_addr) && $stable(int_source_index);
  endproperty
  a_offer_stable: assert property (p_offer_stable)
    else $error("Offer changed before acknowledge.");

endmodule : vip_top

// *** common/vip_pkg.sv ***
package vip_pkg;

  // Sizes of the source set, the vector address and the watchdog count.
  localparam int VIP_NUM_SRC = 31;
  localparam int VIP_IDX_W   = 5;
  localparam int VIP_VEC_W   = 16;
  localparam int VIP_WDT_W   = 16;

  typedef logic [VIP_NUM_SRC-1:0] vip_src_t;
  typedef logic [VIP_IDX_W-1:0]   vip_idx_t;
  typedef logic [VIP_VEC_W-1:0]   vip_vec_t;
  typedef logic [VIP_WDT_W-1:0]   vip_wdt_t;

  // Source positions whose requests are gated by a side condition.
  localparam vip_idx_t VIP_IDX_WDT    = 5'h00;
  localparam vip_idx_t VIP_IDX_SUPPLY = 5'h01;

  // Interval point is the overflow count less one quarter of it.
  localparam int VIP_WDT_QUARTER_SHIFT = 2;

  // Option byte bit that enables the interval request, kept for reference.
  localparam int       VIP_OPT_BYTE_ADDR  = 32'h000000c0;
  localparam int       VIP_OPT_WDT_IRQ_BIT = 7;
  localparam int       VIP_SUPPLY_MODE_BIT = 1;

  // Vector handed out for the break instruction.
  localparam vip_vec_t VIP_SOFT_VECTOR = 16'h007e;

  // Vector table address per source; the index is the default priority.
  localparam vip_vec_t VIP_VECTOR_TABLE [VIP_NUM_SRC] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018,
    16'h001a, 16'h001c, 16'h001e, 16'h0024, 16'h0026, 16'h0028, 16'h002c, 16'h002e,
    16'h0030, 16'h0032, 16'h0036, 16'h0038, 16'h003c, 16'h0040, 16'h0042, 16'h0044,
    16'h0046, 16'h0048, 16'h0052, 16'h0056, 16'h0058, 16'h005a, 16'h005e};

  // Peripheral request lines, most urgent last so that bit order follows priority.
  typedef struct packed {
    logic divider_done_request;
    logic timer_u1_ch2_done;
    logic timer_u1_ch1_done;
    logic timer_u1_ch0_done;
    logic pin_edge_request_d;
    logic timer_u0_ch7_done;
    logic timer_u0_ch6_done;
    logic timer_u0_ch5_done;
    logic timer_u0_ch4_done;
    logic timer_u1_ch3_done;
    logic serial_b_tx_done;
    logic calendar_interval_request;
    logic calendar_cycle_alarm_request;
    logic timer_u0_ch3_done;
    logic timer_u0_ch2_done;
    logic timer_u0_ch1_done;
    logic timer_u0_ch0_done;
    logic serial_a_rx_error;
    logic serial_a_rx_done;
    logic serial_a_tx_done;
    logic clocked_serial_a_done;
    logic two_wire_a_done;
    logic radio_link_serial_done;
    logic dma_second_done;
    logic dma_first_done;
    logic serial_c_rx_error;
    logic serial_c_rx_done;
    logic serial_c_tx_done;
    logic pin_edge_request_c;
    logic pin_edge_request_b;
    logic pin_edge_request_a;
    logic supply_monitor_request;
  } vip_req_s;

  // Result of the priority search.
  typedef struct packed {
    logic     found;
    vip_idx_t idx;
    vip_vec_t vec;
  } vip_pick_s;

  typedef enum logic [1:0] {
    VIP_ST_IDLE  = 2'b01,
    VIP_ST_OFFER = 2'b10
  } vip_state_e;

  // Whole state of the controller.
  typedef struct packed {
    vip_state_e fsm;
    vip_src_t   pend;
    logic       soft_pend;
    logic       wdt_above;
    logic       int_request;
    logic       int_software;
    vip_idx_t   int_index;
    vip_vec_t   int_vector;
  } vip_state_s;

  localparam vip_state_s VIP_STATE_RST = '{
    fsm:          VIP_ST_IDLE,
    pend:         '0,
    soft_pend:    1'b0,
    wdt_above:    1'b0,
    int_request:  1'b0,
    int_software: 1'b0,
    int_index:    '0,
    int_vector:   '0};

endpackage : vip_pkg

// *** design/vip_prio_enc.sv ***
`timescale 1ns/100ps
module vip_prio_enc (
  // Unmasked pending sources.
  input  wire vip_pkg::vip_src_t  cand,
  // Winning source and its vector.
  output vip_pkg::vip_pick_s      pick
);
  import vip_pkg::*;

  logic [VIP_NUM_SRC:0] blocked;
  vip_src_t             grant;

  // A source wins only when no source of lower index is a candidate.
  assign blocked[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < VIP_NUM_SRC; g = g + 1) begin : g_chain
      assign blocked[g+1] = blocked[g] | cand[g];
      assign grant[g]     = cand[g] & ~blocked[g];
    end
  endgenerate

  // Grant is one-hot, so OR-ing the index and vector of every granted entry is exact.
  always_comb begin
    pick.found = blocked[VIP_NUM_SRC];
    pick.idx   = '0;
    pick.vec   = '0;
    for (int i = 0; i < VIP_NUM_SRC; i++) begin
      if (grant[i]) begin
        pick.idx = pick.idx | vip_idx_t'(i);
        pick.vec = pick.vec | VIP_VECTOR_TABLE[i];
      end
    end
  end

endmodule : vip_prio_enc

// *** sim/vip_cpu_model.sv ***
`timescale 1ns/100ps
module vip_cpu_model (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Offer from the controller.
  input  wire logic               int_request,
  input  wire vip_pkg::vip_vec_t  int_vector_addr,
  input  wire vip_pkg::vip_idx_t  int_source_index,
  input  wire logic               int_software,
  // Cycles to wait before taking an offer.
  input  wire logic [1:0]         ack_delay,
  // Acknowledge and the record of what was taken.
  output logic                    cpu_ack,
  output logic                    taken,
  output vip_pkg::vip_vec_t       taken_vec,
  output vip_pkg::vip_idx_t       taken_idx,
  output logic                    taken_sw
);
  import vip_pkg::*;

  logic [1:0] wait_cnt;

  // One offer at a time; the record is made at the acknowledge edge, before the offer drops.
  always_ff @(posedge sys_clk) begin
    taken <= 1'b0;
    if (reset) begin
      cpu_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (cpu_ack) begin
      cpu_ack   <= 1'b0;
      taken     <= int_request;
      taken_vec <= int_vector_addr;
      taken_idx <= int_source_index;
      taken_sw  <= int_software;
    end else if (int_request) begin
      if (wait_cnt >= ack_delay) begin
        cpu_ack  <= 1'b1;
        wait_cnt <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end

endmodule : vip_cpu_model

// *** sim/vectored_interrupt_prioritizer_test.sv ***
`timescale 1ns/100ps
module vectored_interrupt_prioritizer_test;
  import vip_pkg::*;

  localparam logic [15:0] exp_vec [31] = '{16'h0004, 16'h0006, 16'h0008, 16'h0010, 16'h0012, 16'h0014,
    16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0024, 16'h0026, 16'h0028, 16'h002c, 16'h002e,
    16'h0030, 16'h0032, 16'h0036, 16'h0038, 16'h003c, 16'h0040, 16'h0042, 16'h0044, 16'h0046, 16'h0048,
    16'h0052, 16'h0056, 16'h0058, 16'h005a, 16'h005e};

  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  vip_req_s   src_req = '0;
  vip_src_t   src_mask = '0;
  logic       break_instruction = 1'b0;
  vip_wdt_t   wd_cnt = '0;
  vip_wdt_t   wd_ovf = 16'h0100;
  logic       wd_en = 1'b0;
  logic       sm_mode = 1'b0;
  logic [1:0] ack_delay = 2'h0;
  logic       cpu_ack, int_request, int_software, taken, taken_sw;
  vip_vec_t   int_vector_addr, taken_vec;
  vip_idx_t   int_source_index, taken_idx;
  vip_src_t   pending_flags, exp, m;
  logic [31:0] r;
  int         mismatches = 0;
  int         comparisons = 0;
  int         seed = 32'hc26a;
  int         hits;

  always #12.5 sys_clk = ~sys_clk;

  vip_top dut (.sys_clk(sys_clk), .reset(reset), .src_req(src_req), .src_mask(src_mask),
    .break_instruction(break_instruction), .watchdog_count(wd_cnt), .watchdog_overflow_count(wd_ovf),
    .watchdog_interval_irq_enable(wd_en), .supply_monitor_mode_bit(sm_mode), .cpu_ack(cpu_ack),
    .int_vector_addr(int_vector_addr), .int_request(int_request), .int_software(int_software),
    .int_source_index(int_source_index), .pending_flags(pending_flags));

  vip_cpu_model cpu (.sys_clk(sys_clk), .reset(reset), .int_request(int_request),
    .int_vector_addr(int_vector_addr), .int_source_index(int_source_index), .int_software(int_software),
    .ack_delay(ack_delay), .cpu_ack(cpu_ack), .taken(taken), .taken_vec(taken_vec), .taken_idx(taken_idx),
    .taken_sw(taken_sw));

  // Three transmit-done lines share one source, so request bits 10 to 12 all map to priority 11.
  function automatic int prio_of(input int b);
    return (b < 10) ? b + 1 : ((b < 13) ? 11 : b - 1);
  endfunction : prio_of

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic pulse(input logic [31:0] bits, input logic b);
    @(posedge sys_clk);
    src_req           <= vip_req_s'(bits);
    break_instruction <= b;
    @(posedge sys_clk);
    src_req           <= '0;
    break_instruction <= 1'b0;
  endtask : pulse

  // Bounded wait for the core to take an offer, then compare what it fetched.
  task automatic take(input logic [15:0] v, input logic [4:0] i, input logic s);
    int n;
    n = 0;
    #1;
    while (taken !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(taken, 1'b1);
    check(taken_vec, v);
    check(taken_idx, i);
    check(taken_sw, s);
    @(posedge sys_clk);
  endtask : take

  // Counts cycles in which an offer shows up while none may.
  task automatic quiet(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      h += (int_request !== 1'b0 || taken !== 1'b0);
    end
  endtask : quiet

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // A hang is cut short well beyond the thousand or so cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    check({int_request, int_software, int_source_index, int_vector_addr}, 32'h0);
    check(pending_flags, 31'h0);
    $display("test reset done");
    @(posedge sys_clk);
    for (int b = 0; b < 32; b++) begin
      ack_delay <= 2'($random(seed));
      pulse(32'h1 << b, 1'b0);
      take(exp_vec[prio_of(b)], 5'(prio_of(b)), 1'b0);
    end
    $display("test sources done");
    for (int k = 0; k < 8; k++) begin
      r   = $random(seed);
      m   = 31'($random(seed)) & 31'($random(seed));
      exp = '0;
      for (int b = 0; b < 32; b++)
        if (r[b]) exp[prio_of(b)] = 1'b1;
      @(posedge sys_clk);
      src_mask  <= m;
      ack_delay <= 2'($random(seed));
      pulse(r, 1'b0);
      for (int p = 0; p < 31; p++)
        if (exp[p] && !m[p]) take(exp_vec[p], 5'(p), 1'b0);
      quiet(10, hits);
      check(hits, 0);
      check(pending_flags, exp & m);
      @(posedge sys_clk);
      src_mask <= '0;
      for (int p = 0; p < 31; p++)
        if (exp[p] && m[p]) take(exp_vec[p], 5'(p), 1'b0);
    end
    $display("test priority and mask done");
    pulse(32'h1, 1'b1);
    take(16'h007e, 5'h00, 1'b1);
    take(16'h0006, 5'h01, 1'b0);
    @(posedge sys_clk);
    sm_mode <= 1'b1;
    pulse(32'h1, 1'b0);
    quiet(10, hits);
    check(hits, 0);
    check(pending_flags, 31'h0);
    $display("test break and supply done");
    @(posedge sys_clk);
    sm_mode <= 1'b0;
    wd_cnt  <= 16'h00c0;
    quiet(10, hits);
    check(hits, 0);
    @(posedge sys_clk);
    wd_cnt <= 16'h0000;
    wd_en  <= 1'b1;
    @(posedge sys_clk);
    wd_cnt <= 16'h00bf;
    quiet(10, hits);
    check(hits, 0);
    @(posedge sys_clk);
    wd_cnt <= 16'h00c0;
    take(16'h0004, 5'h00, 1'b0);
    wd_cnt <= 16'h0000;
    $display("test watchdog done");
    // A slow core leaves the offer up long enough to mask it; the flag must wait for the unmask.
    ack_delay <= 2'h3;
    pulse(32'h80, 1'b0);
    @(posedge sys_clk);
    src_mask <= '1;
    quiet(10, hits);
    check(hits, 0);
    check(pending_flags, 31'h100);
    @(posedge sys_clk);
    src_mask <= '0;
    take(16'h001a, 5'h08, 1'b0);
    // A line held high through its acknowledge sets the flag again, so it is offered once more.
    ack_delay <= 2'h0;
    @(posedge sys_clk);
    src_req <= vip_req_s'(32'h8000);
    repeat (4) @(posedge sys_clk);
    src_req <= '0;
    take(16'h002c, 5'h0e, 1'b0);
    take(16'h002c, 5'h0e, 1'b0);
    quiet(10, hits);
    check(hits, 0);
    $display("test withdraw and set wins done");
    @(posedge sys_clk);
    src_mask <= '1;
    pulse(32'hffffffff, 1'b0);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset    <= 1'b0;
    src_mask <= '0;
    quiet(10, hits);
    check(hits, 0);
    check(pending_flags, 31'h0);
    $display("test mid reset done");
    final_report();
  end

endmodule : vectored_interrupt_prioritizer_test
